/* File: logic/rss_start_sync.sv */
// Ramp start synchroniser: trigger detection, start delay, pin output, deferred writes
module rss_start_sync
	import rss_pkg::*;
#(
	parameter int DW = RSS_DW
)
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Host register port, done strobe marks a complete datagram
	input  wire logic              dgram_done_i,
	input  wire logic              dgram_write_i,
	input  wire logic [RSS_AW-1:0] dgram_addr_i,
	input  wire logic [DW-1:0]     dgram_wdata_i,
	output logic      [DW-1:0]     rdata_o,
	// Internal ramp events
	input  wire logic              target_reached_i,
	input  wire logic              velocity_reached_i,
	input  wire logic              position_compare_event_i,
	// Start pin
	input  wire logic              start_pin_i,
	output logic                   start_pin_o,
	output logic                   start_pin_oe_o,
	// Active parameters and start outputs
	output logic      [DW-1:0]     target_position_o,
	output logic      [DW-1:0]     maximum_velocity_o,
	output logic      [RSS_MODE_BITS-1:0] ramp_profile_select_o,
	output logic      [DW-1:0]     step_a_o,
	output logic                   start_pulse_o,
	output logic                   shadow_load_o,
	output logic                   new_ramp_o
);
	typedef struct packed {
		rss_state_e                  state;
		logic [RSS_CFG_BITS-1:0]     cfg;
		logic [DW-1:0]               out_add;
		logic [DW-1:0]               delay;
		logic [DW-1:0]               cnt;
		logic [DW:0]                 out_cnt;
		logic [DW-1:0]               pend_target;
		logic [DW-1:0]               pend_maximum_velocity;
		logic [RSS_MODE_BITS-1:0]    pend_mode;
		logic [DW-1:0]               pend_gear;
		logic [4:0]                  pending;
		logic [DW-1:0]               target;
		logic [DW-1:0]               maximum_velocity;
		logic [RSS_MODE_BITS-1:0]    mode;
		logic [DW-1:0]               gear;
		logic                        start;
		logic                        shadow;
		logic                        new_ramp;
		logic                        pin_q;
		logic                        pin_out;
		logic                        pin_oe;
		logic                        tr_q;
		logic                        vr_q;
		logic                        pc_q;
		logic [DW-1:0]               rdata;
	} rss_reg_s;

	rss_reg_s r;
	rss_reg_s next_r;
	logic     pin_level;
	logic     pol;
	logic     pin_in_mode;
	logic     ext_trig;
	logic     int_trig;
	logic     fire;
	logic     wr;

	rss_pin_sync u_pin_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (start_pin_i),
		.level_o (pin_level)
	);

	assign pol         = r.cfg[RSS_POL];
	assign pin_in_mode = r.cfg[RSS_TRG_PIN];
	// Active transition of the filtered pin, polarity selected
	assign ext_trig    = pin_in_mode && (pin_level != r.pin_q) && (pin_level == pol);
	// Rising edges of enabled internal events
	assign int_trig    = (r.cfg[RSS_TRG_TARGET] && target_reached_i && !r.tr_q)
	                  || (r.cfg[RSS_TRG_VEL] && velocity_reached_i && !r.vr_q)
	                  || (r.cfg[RSS_TRG_POSCMP] && position_compare_event_i && !r.pc_q);
	assign wr          = dgram_done_i && dgram_write_i;

	always_comb begin
		next_r          = r;
		fire            = 1'b0;
		next_r.pin_q    = pin_level;
		next_r.tr_q     = target_reached_i;
		next_r.vr_q     = velocity_reached_i;
		next_r.pc_q     = position_compare_event_i;
		next_r.pin_oe   = !pin_in_mode;
		next_r.new_ramp = 1'b0;
		next_r.shadow   = 1'b0;

		// Trigger handling and start delay
		unique case (r.state)
			RSS_IDLE: begin
				if (ext_trig && r.cfg[RSS_IMMEDIATE]) begin
					fire = 1'b1;
				end else if (ext_trig || int_trig) begin
					if (r.delay == '0) begin
						fire = 1'b1;
					end else begin
						next_r.cnt   = r.delay;
						next_r.state = RSS_DELAY;
					end
				end
			end
			RSS_DELAY: begin
				// Other triggers ignored while counting, except an immediate pin trigger
				if (ext_trig && r.cfg[RSS_IMMEDIATE]) begin
					fire         = 1'b1;
					next_r.state = RSS_IDLE;
				end else if (r.cnt == DW'(1)) begin
					fire         = 1'b1;
					next_r.state = RSS_IDLE;
				end else begin
					next_r.cnt   = r.cnt - DW'(1);
				end
			end
		endcase
		next_r.start = fire;

		// Start pin output stretch
		if (fire && !pin_in_mode) begin
			next_r.out_cnt = {1'b0, r.out_add} + (DW+1)'(1);
		end else if (r.out_cnt != '0) begin
			next_r.out_cnt = r.out_cnt - (DW+1)'(1);
		end
		next_r.pin_out = (next_r.out_cnt != '0) ? pol : !pol;

		// Deferred assignments taken on the internal start
		if (r.start) begin
			if (r.pending[RSS_EN_TARGET]) begin
				next_r.target   = r.pend_target;
				next_r.new_ramp = 1'b1;
			end
			if (r.pending[RSS_EN_MAXIMUM_VELOCITY]) begin
				next_r.maximum_velocity = r.pend_maximum_velocity;
			end
			if (r.pending[RSS_EN_MODE]) begin
				next_r.mode = r.pend_mode;
			end
			if (r.pending[RSS_EN_GEAR]) begin
				next_r.gear = r.pend_gear;
			end
			next_r.shadow  = r.cfg[RSS_EN_SHADOW];
			next_r.pending = '0;
		end

		// Host writes at datagram end; a write in the start cycle stays pending
		if (wr) begin
			unique case (dgram_addr_i)
				RSS_ADDR_CONFIG:  next_r.cfg     = dgram_wdata_i[RSS_CFG_BITS-1:0];
				RSS_ADDR_OUT_ADD: next_r.out_add = dgram_wdata_i;
				RSS_ADDR_DELAY:   next_r.delay   = dgram_wdata_i;
				RSS_ADDR_TARGET: begin
					if (r.cfg[RSS_EN_TARGET]) begin
						next_r.pend_target            = dgram_wdata_i;
						next_r.pending[RSS_EN_TARGET] = 1'b1;
					end else begin
						next_r.target   = dgram_wdata_i;
						next_r.new_ramp = 1'b1;
					end
				end
				RSS_ADDR_MAXIMUM_VELOCITY: begin
					if (r.cfg[RSS_EN_MAXIMUM_VELOCITY]) begin
						next_r.pend_maximum_velocity            = dgram_wdata_i;
						next_r.pending[RSS_EN_MAXIMUM_VELOCITY] = 1'b1;
					end else begin
						next_r.maximum_velocity = dgram_wdata_i;
					end
				end
				RSS_ADDR_MODE: begin
					if (r.cfg[RSS_EN_MODE]) begin
						next_r.pend_mode            = dgram_wdata_i[RSS_MODE_BITS-1:0];
						next_r.pending[RSS_EN_MODE] = 1'b1;
					end else begin
						next_r.mode = dgram_wdata_i[RSS_MODE_BITS-1:0];
					end
				end
				RSS_ADDR_GEAR: begin
					if (r.cfg[RSS_EN_GEAR]) begin
						next_r.pend_gear            = dgram_wdata_i;
						next_r.pending[RSS_EN_GEAR] = 1'b1;
					end else begin
						next_r.gear = dgram_wdata_i;
					end
				end
				default: ;
			endcase
		end

		// Read data, registered
		unique case (dgram_addr_i)
			RSS_ADDR_CONFIG:  next_r.rdata = DW'(r.cfg);
			RSS_ADDR_OUT_ADD: next_r.rdata = r.out_add;
			RSS_ADDR_DELAY:   next_r.rdata = r.delay;
			RSS_ADDR_TARGET:  next_r.rdata = r.target;
			RSS_ADDR_MAXIMUM_VELOCITY:    next_r.rdata = r.maximum_velocity;
			RSS_ADDR_MODE:    next_r.rdata = DW'(r.mode);
			RSS_ADDR_GEAR:    next_r.rdata = r.gear;
			RSS_ADDR_STATUS:  next_r.rdata = DW'({r.pending, r.state == RSS_DELAY});
			default:          next_r.rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r             <= '0;
			r.state       <= RSS_IDLE;
			r.cfg         <= RSS_RST_CONFIG[RSS_CFG_BITS-1:0];
			r.out_add     <= RSS_RST_OUT_ADD;
			r.delay       <= RSS_RST_DELAY;
			r.target      <= RSS_RST_PARAM;
			r.maximum_velocity        <= RSS_RST_PARAM;
			r.gear        <= RSS_RST_PARAM;
			r.pin_q       <= RSS_RST_PIN_LEVEL;
			r.pin_out     <= 1'b1;
			r.pin_oe      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_o               = r.rdata;
	assign start_pin_o           = r.pin_out;
	assign start_pin_oe_o        = r.pin_oe;
	assign target_position_o     = r.target;
	assign maximum_velocity_o    = r.maximum_velocity;
	assign ramp_profile_select_o = r.mode;
	assign step_a_o              = r.gear;
	assign start_pulse_o         = r.start;
	assign shadow_load_o         = r.shadow;
	assign new_ramp_o            = r.new_ramp;
endmodule

/* File: common/rss_pkg.sv */
// Package for the ramp start synchroniser: register map, fields, reset values
package rss_pkg;
	localparam int          RSS_AW             = 7;
	localparam int          RSS_DW             = 32;
	// Register offsets
	localparam logic [6:0]  RSS_ADDR_CONFIG    = 7'h02;
	localparam logic [6:0]  RSS_ADDR_OUT_ADD   = 7'h11;
	localparam logic [6:0]  RSS_ADDR_DELAY     = 7'h13;
	localparam logic [6:0]  RSS_ADDR_GEAR      = 7'h12;
	localparam logic [6:0]  RSS_ADDR_MODE      = 7'h20;
	localparam logic [6:0]  RSS_ADDR_MAXIMUM_VELOCITY      = 7'h24;
	localparam logic [6:0]  RSS_ADDR_TARGET    = 7'h37;
	localparam logic [6:0]  RSS_ADDR_STATUS    = 7'h7e;
	// start_sync_config fields
	localparam int          RSS_EN_TARGET      = 0;
	localparam int          RSS_EN_MAXIMUM_VELOCITY        = 1;
	localparam int          RSS_EN_MODE        = 2;
	localparam int          RSS_EN_GEAR        = 3;
	localparam int          RSS_EN_SHADOW      = 4;
	localparam int          RSS_TRG_LSB        = 5;
	localparam int          RSS_TRG_PIN        = 5;
	localparam int          RSS_TRG_TARGET     = 6;
	localparam int          RSS_TRG_VEL        = 7;
	localparam int          RSS_TRG_POSCMP     = 8;
	localparam int          RSS_POL            = 9;
	localparam int          RSS_IMMEDIATE      = 10;
	localparam int          RSS_CFG_BITS       = 11;
	localparam int          RSS_MODE_BITS      = 3;
	// Reset values
	localparam logic [31:0] RSS_RST_CONFIG     = 32'h0000_0000;
	localparam logic [31:0] RSS_RST_OUT_ADD    = 32'h0000_0000;
	localparam logic [31:0] RSS_RST_DELAY      = 32'h0000_0000;
	localparam logic [31:0] RSS_RST_PARAM      = 32'h0000_0000;
	localparam logic        RSS_RST_PIN_LEVEL  = 1'b1;
	// Pin input synchroniser length
	localparam int          RSS_SYNC_STAGES    = 3;
	typedef enum logic [1:0] {
		RSS_IDLE  = 2'b01,
		RSS_DELAY = 2'b10
	} rss_state_e;
endpackage

/* File: logic/rss_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the start pin input
module rss_pin_sync
	import rss_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin in, filtered level out
	input  wire logic pin_i,
	output logic      level_o
);
	logic [RSS_SYNC_STAGES-1:0] sync;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync    <= {RSS_SYNC_STAGES{RSS_RST_PIN_LEVEL}};
			level_o <= RSS_RST_PIN_LEVEL;
		end else begin
			sync <= {sync[RSS_SYNC_STAGES-2:0], pin_i};
			// Change is taken only when second and third stage agree
			if (sync[1] == sync[2]) begin
				level_o <= sync[2];
			end
		end
	end
endmodule

/* File: test/rss_checker.sv */
// Port checker for the ramp start synchroniser
module rss_checker
	import rss_pkg::*;
#(parameter int DW = RSS_DW)
(
	// Clock, reset and host port
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              dgram_done_i,
	input wire logic              dgram_write_i,
	input wire logic [RSS_AW-1:0] dgram_addr_i,
	input wire logic [DW-1:0]     dgram_wdata_i,
	// Watched outputs
	input wire logic              start_pin_o,
	input wire logic              start_pin_oe_o,
	input wire logic [DW-1:0]     target_position_o,
	input wire logic [DW-1:0]     maximum_velocity_o,
	input wire logic              start_pulse_o,
	input wire logic              shadow_load_o,
	input wire logic              new_ramp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cfg, dly, add, zc, ac;
	logic        wr, tw, act;
	assign wr  = dgram_done_i && dgram_write_i;
	assign tw  = wr && dgram_addr_i == RSS_ADDR_TARGET;
	assign act = start_pin_o == cfg[RSS_POL];
	// Copies of the timing registers, trigger-off time and active run length
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg <= RSS_RST_CONFIG;
			dly <= RSS_RST_DELAY;
			add <= RSS_RST_OUT_ADD;
			zc  <= '0;
			ac  <= '0;
		end else begin
			if (wr && dgram_addr_i == RSS_ADDR_CONFIG) cfg <= dgram_wdata_i;
			if (wr && dgram_addr_i == RSS_ADDR_DELAY) dly <= dgram_wdata_i;
			if (wr && dgram_addr_i == RSS_ADDR_OUT_ADD) add <= dgram_wdata_i;
			zc <= (|cfg[8:5]) ? '0 : zc + 32'h1;
			ac <= (act && start_pin_oe_o) ? ac + 32'h1 : '0;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_wr(a, en);
		wr && dgram_addr_i == a && !en;
	endsequence
	sequence s_run_end;
		start_pin_oe_o && $past(act) && !act && $past(cfg, 2) == cfg;
	endsequence
	AST_OE: assert property ($past(cfg) == cfg |-> start_pin_oe_o == !cfg[RSS_TRG_PIN])
		else $error("pin direction wrong");
	AST_PIN_ACT: assert property (start_pulse_o && start_pin_oe_o && $past(cfg) == cfg |-> act)
		else $error("pin not active with start");
	AST_OUT_LEN: assert property (s_run_end |-> ac == add + 32'h1)
		else $error("pin active length wrong");
	AST_NO_TRIG: assert property (zc > dly + 32'h2 |-> !start_pulse_o)
		else $error("start with no trigger");
	AST_SHADOW: assert property (start_pulse_o && cfg[RSS_EN_SHADOW] |=> shadow_load_o)
		else $error("shadow load missing");
	AST_TGT_NOW: assert property (s_wr(RSS_ADDR_TARGET, cfg[RSS_EN_TARGET])
		|=> target_position_o == $past(dgram_wdata_i)) else $error("target not taken");
	AST_MAXIMUM_VELOCITY_NOW: assert property (s_wr(RSS_ADDR_MAXIMUM_VELOCITY, cfg[RSS_EN_MAXIMUM_VELOCITY])
		|=> maximum_velocity_o == $past(dgram_wdata_i)) else $error("velocity not taken");
	AST_TGT_HOLD: assert property (target_position_o != $past(target_position_o) |-> new_ramp_o)
		else $error("target moved silently");
	AST_RAMP_CAUSE: assert property (new_ramp_o |-> $past(start_pulse_o) || $past(tw))
		else $error("ramp without cause");
endmodule
bind rss_start_sync rss_checker #(.DW(DW)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .dgram_done_i(dgram_done_i),
	.dgram_write_i(dgram_write_i), .dgram_addr_i(dgram_addr_i),
	.dgram_wdata_i(dgram_wdata_i), .start_pin_o(start_pin_o),
	.start_pin_oe_o(start_pin_oe_o), .target_position_o(target_position_o),
	.maximum_velocity_o(maximum_velocity_o), .start_pulse_o(start_pulse_o),
	.shadow_load_o(shadow_load_o), .new_ramp_o(new_ramp_o)
);

/* File: test/rss_pin_partner.sv */
// External device sharing the start pin
module rss_pin_partner (
	// Clock and control
	input wire logic clk_i,
	input wire logic pol_i,
	input wire logic fire_i,
	// Device side of the pin
	input wire logic oe_i,
	input wire logic dev_pin_i,
	output logic     pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hold = '0;
	// Active level held long enough to pass the input filter
	always_ff @(posedge clk_i) begin
		hold <= fire_i ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
	end
	assign pin_o = oe_i ? dev_pin_i : ((hold != 3'h0) ? pol_i : !pol_i);
endmodule

/* File: test/tb.sv */
// Self-checking bench for the ramp start synchroniser
module tb
	import rss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        done = 0, wrt = 0, pol = 0, fire = 0;
	logic [2:0]  ev = '0;
	logic [6:0]  addr = '0;
	logic [31:0] wd = '0;
	logic [31:0] rdata, tgt, maximum_velocity, gear;
	logic [2:0]  mode;
	logic        pin, pin_o, oe, sp, sh, nr;
	int          err_count = 0, n_tests = 0, c;
	int          dl[3] = '{0, 3, 1};
	int          ad[3] = '{0, 2, 1};
	rss_start_sync uut (
		.clk_i(clk_i), .rst_i(rst_i), .dgram_done_i(done), .dgram_write_i(wrt),
		.dgram_addr_i(addr), .dgram_wdata_i(wd), .rdata_o(rdata),
		.target_reached_i(ev[0]), .velocity_reached_i(ev[1]),
		.position_compare_event_i(ev[2]), .start_pin_i(pin), .start_pin_o(pin_o),
		.start_pin_oe_o(oe), .target_position_o(tgt), .maximum_velocity_o(maximum_velocity),
		.ramp_profile_select_o(mode), .step_a_o(gear), .start_pulse_o(sp),
		.shadow_load_o(sh), .new_ramp_o(nr)
	);
	rss_pin_partner u_far (
		.clk_i(clk_i), .pol_i(pol), .fire_i(fire), .oe_i(oe), .dev_pin_i(pin_o), .pin_o(pin)
	);
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task tick;
		@(posedge clk_i);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [6:0] a, input logic [31:0] d);
		done = 1;
		wrt = 1;
		addr = a;
		wd = d;
		tick;
		done = 0;
		wrt = 0;
		tick;
	endtask
	task rd(input logic [6:0] a, input logic [31:0] exp);
		addr = a;
		tick;
		chk(rdata, exp);
	endtask
	task trig(input int n, input int k);
		ev[k] = 1'b1;
		// Start follows the detecting edge by the delay count
		repeat (n + 1) begin
			chk(32'(sp), 32'h0);
			tick;
		end
		chk(32'(sp), 32'h1);
		chk(32'(pin_o), 32'(pol));
		ev[k] = 1'b0;
	endtask
	task quiet;
		repeat (8) begin
			tick;
			chk(32'(sp), 32'h0);
		end
	endtask
	task wait_sp;
		c = 0;
		while (sp !== 1'b1 && c < 40) begin
			tick;
			c++;
		end
	endtask
	task pin_cfg(input logic [31:0] v);
		wr(RSS_ADDR_CONFIG, v & ~32'h20);
		pol = v[9];
		wr(RSS_ADDR_CONFIG, v);
	endtask
	task fin(input string s);
		$display("test %s done", s);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		#1 rst_i = 0;
		chk(32'({oe, pin_o}), 32'h3);
		rd(RSS_ADDR_CONFIG, RSS_RST_CONFIG);
		rd(RSS_ADDR_OUT_ADD, RSS_RST_OUT_ADD);
		rd(RSS_ADDR_DELAY, RSS_RST_DELAY);
		rd(7'h05, 32'h0);
		wr(RSS_ADDR_DELAY, 32'h3);
		rd(RSS_ADDR_DELAY, 32'h3);
		fin("registers");
		for (int i = 0; i < 3; i++) begin
			pol = i[0];
			wr(RSS_ADDR_CONFIG, 32'(pol) << 9 | 32'h10 | 32'h40 << i);
			wr(RSS_ADDR_DELAY, 32'(dl[i]));
			wr(RSS_ADDR_OUT_ADD, 32'(ad[i]));
			trig(dl[i], i);
			tick;
			chk(32'(sh), 32'h1);
			repeat (ad[i]) tick;
			chk(32'(pin_o), 32'(!pol));
		end
		fin("delay and output");
		wr(RSS_ADDR_CONFIG, 32'h4f);
		wr(RSS_ADDR_DELAY, 32'h2);
		wr(RSS_ADDR_TARGET, 32'h100);
		wr(RSS_ADDR_MAXIMUM_VELOCITY, 32'h20);
		wr(RSS_ADDR_MODE, 32'h6);
		wr(RSS_ADDR_GEAR, 32'h7);
		rd(RSS_ADDR_STATUS, 32'h1e);
		chk(tgt, RSS_RST_PARAM);
		trig(2, 0);
		tick;
		chk(tgt, 32'h100);
		chk(maximum_velocity, 32'h20);
		chk(32'(mode), 32'h6);
		chk(gear, 32'h7);
		chk(32'(nr), 32'h1);
		tick;
		trig(2, 0);
		tick;
		chk(32'(nr), 32'h0);
		wr(RSS_ADDR_CONFIG, 32'h40);
		wr(RSS_ADDR_MAXIMUM_VELOCITY, 32'h55);
		chk(maximum_velocity, 32'h55);
		wr(RSS_ADDR_TARGET, 32'h200);
		chk(tgt, 32'h200);
		fin("deferred writes");
		wr(RSS_ADDR_CONFIG, 32'hc0);
		wr(RSS_ADDR_DELAY, 32'h6);
		fork
			trig(6, 0);
			begin
				repeat (2) tick;
				ev[1] = 1'b1;
			end
		join
		quiet;
		ev = '0;
		wr(RSS_ADDR_CONFIG, 32'h0);
		ev = 3'h7;
		quiet;
		ev = '0;
		fin("ignored triggers");
		pin_cfg(32'h20);
		chk(32'(oe), 32'h0);
		fire = 1;
		tick;
		fire = 0;
		wait_sp;
		chk(32'(c > 6 && c < 16), 32'h1);
		wr(RSS_ADDR_DELAY, 32'h1e);
		pin_cfg(32'h660);
		ev[0] = 1'b1;
		tick;
		fire = 1;
		tick;
		fire = 0;
		wait_sp;
		chk(32'(c < 10), 32'h1);
		ev = '0;
		fin("pin input");
		wrap_up;
	end
endmodule
